// File: inc/isic_defines.vh
// Register offsets, field positions, reset values and codes for the issue control block.
`ifndef ISIC_DEFINES_VH
`define ISIC_DEFINES_VH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_STAT_DESIG 8'h08
`define OFS_EXT_FLEN 8'h0C
`define OFS_NORM_EXIT 8'h10
`define OFS_ERR_EXIT 8'h14
`define OFS_RET 8'h18
`define OFS_CMREF 8'h1C
`define CTRL_RESET 4'h0
`define CTRL_NONSEQ 0
`define CTRL_DIS_LO 1
`define CTRL_DIS_HI 2
`define DIS_NONE 2'h0
`define DIS_TEN 2'h1
`define DIS_FOUR 2'h2
`define STACK_RANKS 12
`define DIS_TEN_RANKS 10
`define DIS_FOUR_RANKS 4
`define PREFETCH_AHEAD 18'h0002
`define XCHG_LAST 3'h7
`define SD_EXIT_MODE 17
`define SD_MONITOR_MODE 16
`define SD_EXT_BLOCK_RANGE 9
`define SD_MEM_BLOCK_RANGE 8
`define SD_EXT_DIRECT_RANGE 7
`define SD_PROGRAM_RANGE 5
`define OP_ERROR_EXIT 6'h00
`define OP_GROUP01 6'h01
`define OP_JUMP_BK 6'h02
`define OP_XBRANCH 6'h03
`define OP_BEQ 6'h04
`define OP_BNE 6'h05
`define OP_BGE 6'h06
`define OP_BLT 6'h07
`define SUB_RETURN_JUMP 3'h0
`define SUB_COPY_TO_MEM 3'h1
`define SUB_COPY_TO_EXT 3'h2
`define SUB_EXCHANGE 3'h3
`define EXP_OUT_POS 11'h3FF
`define EXP_OUT_NEG 11'h400
`define EXP_INDEF_POS 11'h3FE
`define EXP_INDEF_NEG 11'h401
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/instruction_stack_issue_control.v
// Instruction word stack, parcel issue, jump and exchange control with an AXI4-Lite slave.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "isic_defines.vh"

module instruction_stack_issue_control (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg mem_req,
  output reg [17:0] mem_addr,
  input wire mem_ack,
  input wire [59:0] mem_data,
  input wire xchg_req,
  input wire [17:0] xchg_addr,
  input wire issue_ok,
  input wire [17:0] bi_val,
  input wire [17:0] bj_val,
  input wire [59:0] xj_val,
  input wire [17:0] a0_val,
  input wire [59:0] x0_val,
  input wire direct_req,
  input wire [21:0] direct_addr,
  output reg [59:0] current_instr_word,
  output reg [2:0] parcels_left,
  output reg issue_pulse,
  output reg [29:0] issued_instr,
  output reg issued_long,
  output reg copy_start,
  output reg copy_to_ext,
  output reg [17:0] copy_count,
  output reg [17:0] copy_cm_addr,
  output reg [21:0] copy_ext_addr,
  output reg [17:0] ret_addr,
  output reg running
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_XCHG = 3'b100;

  reg [59:0] instr_word_stack [0:11];
  reg [17:0] instr_addr_stack [0:11];
  reg [11:0] vld_q;
  reg [2:0] st_q;
  reg [17:0] p_q;
  reg [17:0] nxt_q;
  reg [2:0] xw_q;
  reg [17:0] xbase_q;
  reg drop_q;
  reg [3:0] ctrl_q;
  reg [17:0] program_status_designator;
  reg [17:0] cpu_mem_reference_addr;
  reg [17:0] cm_field_length;
  reg [21:0] ext_reference_addr;
  reg [21:0] ext_field_length;
  reg [23:0] normal_exit_addr;
  reg [23:0] error_exit_addr;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg w_strb0_q;

  wire [29:0] lead = current_instr_word[59:30];
  wire [5:0] fm = lead[29:24];
  wire [2:0] fi = lead[23:21];
  wire [17:0] k18 = lead[17:0];
  wire nonseq = ctrl_q[`CTRL_NONSEQ];
  wire [1:0] dis = ctrl_q[`CTRL_DIS_HI:`CTRL_DIS_LO];
  wire [10:0] xexp = xj_val[58:48];
  wire x_oor = (xexp == `EXP_OUT_POS) || (xexp == `EXP_OUT_NEG);
  wire x_ind = (xexp == `EXP_INDEF_POS) || (xexp == `EXP_INDEF_NEG);
  wire [17:0] fetch_gap = nxt_q - p_q;
  wire [17:0] cnt = bj_val + k18;
  wire [21:0] ext_start = x0_val[21:0];
  wire [21:0] ext_end = ext_start + {4'h0, cnt};
  wire [17:0] cm_end = a0_val + cnt;
  wire run = st_q == ST_RUN;
  wire iss = run && (parcels_left != 3'h0) && issue_ok && !xchg_req;
  wire take_xchg = xchg_req && (st_q != ST_XCHG);

  reg p_hit;
  reg t_hit;
  reg [59:0] p_word;
  reg long_op;
  reg take;
  reg [17:0] tgt;
  reg do_void;
  reg go_x;
  reg [17:0] x_to;
  reg is_copy;
  reg err_exit;
  reg [11:0] on;
  integer n;

  // A rank is usable only while valid and not switched off for maintenance.
  always @* begin
    for (n = 0; n < `STACK_RANKS; n = n + 1) begin
      on[n] = vld_q[n] && !(dis == `DIS_TEN && n < `DIS_TEN_RANKS) &&
        !(dis == `DIS_FOUR && n < `DIS_FOUR_RANKS);
    end
  end

  // Search runs low to high so that the newest matching rank wins on duplicates.
  always @* begin
    p_hit = 1'b0;
    t_hit = 1'b0;
    p_word = 60'h0000_0000_0000_000;
    for (n = 0; n < `STACK_RANKS; n = n + 1) begin
      if (on[n] && instr_addr_stack[n] == p_q) begin
        p_hit = 1'b1;
        p_word = instr_word_stack[n];
      end
      if (on[n] && instr_addr_stack[n] == tgt) begin
        t_hit = 1'b1;
      end
    end
  end

  always @* begin
    long_op = 1'b0;
    take = 1'b0;
    tgt = k18;
    do_void = 1'b0;
    go_x = 1'b0;
    x_to = 18'h0_0000;
    is_copy = 1'b0;
    err_exit = 1'b0;
    case (fm)
      `OP_ERROR_EXIT: begin
        err_exit = 1'b1;
        go_x = 1'b1;
        x_to = {1'b0, error_exit_addr[16:0]};
      end
      `OP_GROUP01: begin
        long_op = 1'b1;
        case (fi)
          `SUB_RETURN_JUMP: begin
            take = 1'b1;
            do_void = 1'b1;
          end
          `SUB_COPY_TO_MEM, `SUB_COPY_TO_EXT: is_copy = 1'b1;
          `SUB_EXCHANGE: begin
            go_x = 1'b1;
            if (program_status_designator[`SD_MONITOR_MODE]) begin
              x_to = bj_val + k18;
            end else if (program_status_designator[`SD_EXIT_MODE]) begin
              x_to = k18 + bj_val + cpu_mem_reference_addr;
            end else begin
              x_to = normal_exit_addr[17:0];
            end
          end
          default: long_op = 1'b1;
        endcase
      end
      `OP_JUMP_BK: begin
        long_op = 1'b1;
        take = 1'b1;
        tgt = (fi == 3'h0) ? k18 : bi_val + k18;
        do_void = !nonseq;
      end
      `OP_XBRANCH: begin
        long_op = 1'b1;
        case (fi)
          3'h0: take = xj_val == 60'h0000_0000_0000_000;
          3'h1: take = xj_val != 60'h0000_0000_0000_000;
          3'h2: take = !xj_val[59];
          3'h3: take = xj_val[59];
          3'h4: take = !x_oor;
          3'h5: take = x_oor;
          3'h6: take = !x_ind;
          default: take = x_ind;
        endcase
      end
      `OP_BEQ: begin
        long_op = 1'b1;
        take = bi_val == bj_val;
      end
      `OP_BNE: begin
        long_op = 1'b1;
        take = bi_val != bj_val;
      end
      `OP_BGE: begin
        long_op = 1'b1;
        take = $signed(bi_val) >= $signed(bj_val);
      end
      `OP_BLT: begin
        long_op = 1'b1;
        take = $signed(bi_val) < $signed(bj_val);
      end
      default: long_op = 1'b0;
    endcase
    if (take && fm != `OP_GROUP01 && fm != `OP_JUMP_BK && !t_hit && !nonseq) begin
      do_void = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (n = 0; n < `STACK_RANKS; n = n + 1) begin
        instr_word_stack[n] <= 60'h0000_0000_0000_000;
        instr_addr_stack[n] <= 18'h0_0000;
      end
      vld_q <= 12'h000;
      st_q <= ST_IDLE;
      p_q <= 18'h0_0000;
      nxt_q <= 18'h0_0000;
      xw_q <= 3'h0;
      xbase_q <= 18'h0_0000;
      drop_q <= 1'b0;
      program_status_designator <= 18'h0_0000;
      cpu_mem_reference_addr <= 18'h0_0000;
      cm_field_length <= 18'h0_0000;
      ext_reference_addr <= 22'h00_0000;
      ext_field_length <= 22'h00_0000;
      normal_exit_addr <= 24'h00_0000;
      error_exit_addr <= 24'h00_0000;
      mem_req <= 1'b0;
      mem_addr <= 18'h0_0000;
      current_instr_word <= 60'h0000_0000_0000_000;
      parcels_left <= 3'h0;
      issue_pulse <= 1'b0;
      issued_instr <= 30'h0000_0000;
      issued_long <= 1'b0;
      copy_start <= 1'b0;
      copy_to_ext <= 1'b0;
      copy_count <= 18'h0_0000;
      copy_cm_addr <= 18'h0_0000;
      copy_ext_addr <= 22'h00_0000;
      ret_addr <= 18'h0_0000;
      running <= 1'b0;
    end else begin
      issue_pulse <= iss;
      copy_start <= 1'b0;
      running <= st_q == ST_RUN;
      if (mem_ack && mem_req) begin
        mem_req <= 1'b0;
        if (drop_q) begin
          drop_q <= 1'b0;
        end else if (st_q == ST_XCHG) begin
          case (xw_q)
            3'h0: p_q <= mem_data[17:0];
            3'h1: cpu_mem_reference_addr <= mem_data[17:0];
            3'h2: cm_field_length <= mem_data[17:0];
            3'h3: program_status_designator <= mem_data[17:0];
            3'h4: ext_reference_addr <= mem_data[21:0];
            3'h5: ext_field_length <= mem_data[21:0];
            3'h6: normal_exit_addr <= mem_data[23:0];
            default: error_exit_addr <= mem_data[23:0];
          endcase
          xw_q <= xw_q + 3'h1;
          if (xw_q == `XCHG_LAST) begin
            st_q <= ST_RUN;
            nxt_q <= p_q;
          end
        end else begin
          for (n = 0; n < `STACK_RANKS - 1; n = n + 1) begin
            instr_word_stack[n] <= instr_word_stack[n + 1];
            instr_addr_stack[n] <= instr_addr_stack[n + 1];
          end
          instr_word_stack[`STACK_RANKS - 1] <= mem_data;
          instr_addr_stack[`STACK_RANKS - 1] <= nxt_q;
          vld_q <= {1'b1, vld_q[11:1]};
          nxt_q <= nxt_q + 18'h0_0001;
        end
      end else if (!mem_req) begin
        if (st_q == ST_XCHG) begin
          mem_req <= 1'b1;
          mem_addr <= xbase_q + {15'h0000, xw_q};
        end else if (run && parcels_left == 3'h0 && !p_hit && fetch_gap != 18'h0_0000 &&
          !take_xchg) begin
          // The word at P was fetched but is gone or switched off, so fetch it again.
          nxt_q <= p_q;
        end else if (run && fetch_gap <= `PREFETCH_AHEAD && !take_xchg) begin
          mem_req <= 1'b1;
          mem_addr <= nxt_q + cpu_mem_reference_addr;
        end
      end
      // Stack hits feed the word register with no memory traffic, which is what keeps loops local.
      if (run && parcels_left == 3'h0 && p_hit && !take_xchg) begin
        current_instr_word <= p_word;
        parcels_left <= 3'h4;
        p_q <= p_q + 18'h0_0001;
      end
      if (direct_req && run && direct_addr >= ext_field_length[21:0]) begin
        program_status_designator[`SD_EXT_DIRECT_RANGE] <= 1'b1;
      end
      if (iss) begin
        issued_instr <= lead;
        issued_long <= long_op;
        if (long_op) begin
          current_instr_word <= {current_instr_word[29:0], 30'h0000_0000};
          parcels_left <= (parcels_left > 3'h2) ? parcels_left - 3'h2 : 3'h0;
        end else begin
          current_instr_word <= {current_instr_word[44:0], 15'h0000};
          parcels_left <= parcels_left - 3'h1;
        end
        if (is_copy) begin
          copy_start <= 1'b1;
          copy_to_ext <= fi == `SUB_COPY_TO_EXT;
          copy_count <= cnt;
          copy_cm_addr <= a0_val + cpu_mem_reference_addr;
          copy_ext_addr <= ext_start + ext_reference_addr;
          if (ext_end > ext_field_length[21:0]) begin
            program_status_designator[`SD_EXT_BLOCK_RANGE] <= 1'b1;
          end
          if (cm_end > cm_field_length) begin
            program_status_designator[`SD_MEM_BLOCK_RANGE] <= 1'b1;
          end
        end
        if (take) begin
          parcels_left <= 3'h0;
          p_q <= tgt;
          if (fm == `OP_GROUP01) begin
            ret_addr <= p_q;
          end
          if (!t_hit || do_void) begin
            nxt_q <= tgt;
          end
        end
        if (err_exit) begin
          program_status_designator[`SD_PROGRAM_RANGE] <= 1'b1;
        end
        if (go_x) begin
          st_q <= ST_XCHG;
          xbase_q <= x_to;
          xw_q <= 3'h0;
          parcels_left <= 3'h0;
        end
      end
      if (take_xchg) begin
        st_q <= ST_XCHG;
        xbase_q <= xchg_addr;
        xw_q <= 3'h0;
        parcels_left <= 3'h0;
      end
      // An outstanding fetch cannot be recalled, so its returning word is thrown away instead.
      if (take_xchg || (iss && (go_x || (take && do_void)))) begin
        vld_q <= 12'h000;
        for (n = 0; n < `STACK_RANKS; n = n + 1) begin
          instr_addr_stack[n] <= 18'h0_0000;
        end
        drop_q <= mem_req && !(mem_ack && st_q != ST_XCHG);
      end
    end
  end

  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case ({aw_addr_q[7:2], 2'b00})
          `OFS_CTRL: if (w_strb0_q) ctrl_q <= w_data_q[3:0];
          `OFS_STATUS, `OFS_STAT_DESIG, `OFS_EXT_FLEN, `OFS_NORM_EXIT, `OFS_ERR_EXIT,
          `OFS_RET, `OFS_CMREF: ;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `OFS_CTRL: s_axi_rdata <= {28'h000_0000, ctrl_q};
          `OFS_STATUS: s_axi_rdata <= {5'h00, vld_q == 12'h000, st_q, parcels_left, 2'h0, p_q};
          `OFS_STAT_DESIG: s_axi_rdata <= {14'h0000, program_status_designator};
          `OFS_EXT_FLEN: s_axi_rdata <= {10'h000, ext_field_length};
          `OFS_NORM_EXIT: s_axi_rdata <= {8'h00, normal_exit_addr};
          `OFS_ERR_EXIT: s_axi_rdata <= {8'h00, error_exit_addr};
          `OFS_RET: s_axi_rdata <= {14'h0000, ret_addr};
          `OFS_CMREF: s_axi_rdata <= {14'h0000, cpu_mem_reference_addr};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// File: verif/cm_model.sv
// Behavioural central memory control answering fetch and exchange reads.
`timescale 1ns/100ps
module cm_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [17:0] mem_addr,
  input wire logic slow,
  output logic mem_ack,
  output logic [59:0] mem_data
);
  logic [59:0] words [0:1023];
  logic [17:0] last_addr;
  int n_fetch;
  int wait_q;
  initial begin
    foreach (words[i]) words[i] = 60'h0;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_data <= 60'h0;
      last_addr <= 18'h0;
      n_fetch <= 0;
      wait_q <= 0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q < (slow ? 3 : 0)) begin
        wait_q <= wait_q + 1;
      end else begin
        mem_ack <= 1'b1;
        mem_data <= words[mem_addr[9:0]];
        last_addr <= mem_addr;
        n_fetch <= n_fetch + 1;
        wait_q <= 0;
      end
    end else begin
      mem_ack <= 1'b0;
      // Released data is inverted on every idle cycle, so a late sample equals the word only on alternate cycles.
      mem_data <= ~mem_data;
    end
  end
endmodule

// File: verif/isic_props.sv
// Checker for handshake, fetch and issue timing at the ports of the issue control block.
`timescale 1ns/100ps
`include "isic_defines.vh"
module isic_props (
  input wire clk,
  input wire rst,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire mem_req,
  input wire [17:0] mem_addr,
  input wire mem_ack,
  input wire xchg_req,
  input wire issue_ok,
  input wire [59:0] current_instr_word,
  input wire [2:0] parcels_left,
  input wire issue_pulse,
  input wire [29:0] issued_instr,
  input wire issued_long,
  input wire running
);
  logic [59:0] cur_q;
  logic [2:0] plen_q;
  logic can_issue_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // The word and count before the issue edge are kept here so shifts can be judged after it.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= 60'h0;
      plen_q <= 3'h0;
      can_issue_q <= 1'b0;
    end else begin
      cur_q <= current_instr_word;
      plen_q <= parcels_left;
      can_issue_q <= running && parcels_left != 3'h0 && issue_ok && !xchg_req;
    end
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("Read not answered next cycle");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |->
    s_axi_rdata == 32'h0000_0000) else $error("Refused read carries data");
  a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("Fetch request not held");
  a_fetch_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("Fetch request kept after answer");
  a_issue_cause: assert property (issue_pulse |-> can_issue_q)
    else $error("Issue without a free slot");
  a_issue_word: assert property (issue_pulse |-> issued_instr == cur_q[59:30])
    else $error("Issued bits differ from leading parcels");
  a_issue_length: assert property (issue_pulse |->
    issued_long == (cur_q[59:54] >= 6'h01 && cur_q[59:54] <= 6'h07)) else $error("Bad length");
  a_parcel_shift: assert property (issue_pulse && !issued_long && plen_q > 3'h2 &&
    issued_instr[29:24] != `OP_ERROR_EXIT |-> current_instr_word[59:15] == cur_q[44:0] &&
    parcels_left == plen_q - 3'h1) else $error("Parcels not shifted by one");
endmodule
bind instruction_stack_issue_control isic_props u_props (
  .clk(clk), .rst(rst), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .xchg_req(xchg_req), .issue_ok(issue_ok), .current_instr_word(current_instr_word),
  .parcels_left(parcels_left), .issue_pulse(issue_pulse), .issued_instr(issued_instr),
  .issued_long(issued_long), .running(running)
);

// File: verif/tb_top.sv
// Self-checking bench: register access, exchange load, stack loop, jumps and exits.
`timescale 1ns/100ps
`include "isic_defines.vh"
module tb_top;
  logic clk, rst, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mem_req, mem_ack, xchg_req, issue_ok, direct_req;
  logic [17:0] mem_addr, xchg_addr, bi_val, bj_val, a0_val, ret_addr, copy_count, copy_cm_addr;
  logic [59:0] mem_data, xj_val, x0_val, current_instr_word;
  logic [21:0] direct_addr, copy_ext_addr;
  logic [2:0] parcels_left;
  logic [29:0] issued_instr;
  logic issue_pulse, issued_long, copy_start, copy_to_ext, running;
  int num_errors, n_checks;
  instruction_stack_issue_control dut (.*);
  cm_model cm (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .slow(slow),
    .mem_ack(mem_ack), .mem_data(mem_data));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (k == 50) begin
      check(1'b0, 1'b1);
      conclude();
    end
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
    if (k == 50) begin
      check(1'b0, 1'b1);
      conclude();
    end
  endtask
  task automatic wait_fetch(input logic [17:0] a);
    int k;
    for (k = 0; k < 2000 && !(mem_req === 1'b1 && mem_addr === a); k++) @(posedge clk);
    check(mem_addr, a);
    if (k == 2000) begin
      check(1'b0, 1'b1);
      conclude();
    end
  endtask
  task automatic t_idle_regs();
    logic [1:0] r;
    reg_check(`OFS_CTRL, 32'h0000_0000, `RESP_OKAY);
    axi_write(8'h40, 32'h0000_0001, r);
    check(r, `RESP_SLVERR);
    axi_write(`OFS_EXT_FLEN, 32'h0000_1234, r);
    check(r, `RESP_OKAY);
    reg_check(`OFS_EXT_FLEN, 32'h0000_0000, `RESP_OKAY);
    reg_check(8'h40, 32'h0000_0000, `RESP_SLVERR);
    check(running, 1'b0);
    check(cm.n_fetch, 0);
  endtask
  task automatic t_exchange();
    int k;
    xchg_addr <= 18'h0_0040;
    xchg_req <= 1'b1;
    @(posedge clk);
    xchg_req <= 1'b0;
    for (k = 0; k < 500 && running !== 1'b1; k++) @(posedge clk);
    check(running, 1'b1);
    if (k == 500) conclude();
    check(cm.last_addr, 18'h0_0047);
    slow <= 1'b0;
    reg_check(`OFS_EXT_FLEN, 32'h000a_bcde, `RESP_OKAY);
    reg_check(`OFS_NORM_EXIT, 32'h00c3_a5f0, `RESP_OKAY);
    reg_check(`OFS_ERR_EXIT, 32'h00fe_0140, `RESP_OKAY);
  endtask
  task automatic t_loop();
    int f;
    int n;
    repeat (100) @(posedge clk);
    f = cm.n_fetch;
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += issue_pulse;
    end
    check(cm.n_fetch, f);
    check(n > 20, 1'b1);
    issue_ok <= 1'b0;
    repeat (3) @(posedge clk);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += issue_pulse;
    end
    check(n, 0);
    issue_ok <= 1'b1;
  endtask
  task automatic t_jumps_and_exits();
    logic [1:0] r;
    int f;
    int k;
    axi_write(`OFS_CTRL, 32'h0000_0002, r);
    bj_val <= 18'h0_0009;
    wait_fetch(18'h0_00a0);
    check(ret_addr, 18'h0_0012);
    bj_val <= 18'h0_0005;
    wait_fetch(18'h0_0140);
    for (k = 0; k < 300 && copy_start !== 1'b1; k++) @(posedge clk);
    check(copy_to_ext, 1'b1);
    check(copy_count, 18'h0_0009);
    check(copy_cm_addr, 18'h0_0080);
    check(copy_ext_addr, 22'h00_0000);
    if (k == 300) conclude();
    repeat (150) @(posedge clk);
    f = cm.n_fetch;
    repeat (200) @(posedge clk);
    check(cm.n_fetch > f, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    logic [59:0] pkg [8];
    pkg = '{60'h10, 60'h80, 60'h3_ffff, 60'h0, 60'h0, 60'ha_bcde, 60'hc3_a5f0, 60'hfe_0140};
    {rst, slow, issue_ok} = 3'h7;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    s_axi_wstrb = 4'hf;
    {xchg_req, xchg_addr, direct_req, direct_addr, a0_val} = 60'h0;
    {xj_val, x0_val} = 120'h0;
    bi_val = 18'h0_0005;
    bj_val = 18'h0_0005;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      cm.words[10'h040 + i] = pkg[i];
      cm.words[10'h140 + i] = pkg[i];
    end
    // The error-exit package starts at a copy to the extended store with a small count.
    cm.words[10'h140] = 60'h30;
    cm.words[10'h0b0] = {6'h01, 3'h2, 3'h0, 18'h0_0004, 6'h08, 9'h0, 6'h08, 9'h0};
    // Short, then a branch to itself when the compared registers match, then short.
    cm.words[10'h090] = {6'h08, 9'h0, 6'h04, 3'h1, 3'h2, 18'h0_0010, 6'h08, 9'h0};
    cm.words[10'h091] = {6'h01, 3'h0, 3'h0, 18'h0_0020, 6'h08, 9'h0, 6'h08, 9'h0};
    t_idle_regs();
    t_exchange();
    t_loop();
    t_jumps_and_exits();
    conclude();
  end
endmodule
